// ---- lba_arbiter.sv ----
`timescale 1ns/1ps
`include "lba_map.svh"

module lba_arbiter (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cpu_grant_in_n,
   input wire logic local_requester_request_n,
   input wire logic bus_own_in_n,
   input wire logic local_data_strobe_in_n,
   input wire lba_pkg::lba_ack_t transfer_size_ack_in_n,
   input wire logic own_req,
   input wire logic reg_sel,
   output logic cpu_request_out_n,
   output logic local_requester_grant_n,
   output logic bus_own_out_n,
   output logic bus_own_oe,
   output logic local_data_strobe_out_n,
   output logic local_data_strobe_oe,
   output lba_pkg::lba_ack_t transfer_size_ack_out_n,
   output logic transfer_size_ack_oe,
   output logic grant_ack,
   output logic cycle_done,
   output lba_pkg::lba_ack_t ack_size,
   output logic arbiter_mode,
   output logic reg_strobe
);
   import lba_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   logic [`LBA_PIN_COUNT-1:0] pins;
   logic [`LBA_PIN_COUNT-1:0] pins_s;
   logic grant_s;
   logic lreq_s;
   logic own_s;
   logic ds_s;
   lba_ack_t ack_s;

   assign pins = {transfer_size_ack_in_n, local_data_strobe_in_n, bus_own_in_n,
                  local_requester_request_n, cpu_grant_in_n};

   lba_sync #(
      .WIDTH(`LBA_PIN_COUNT),
      .IDLE(`LBA_PIN_IDLE)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pins(pins),
      .pins_s(pins_s)
   );

   // active-high views of grant, request and strobe; ownership and acks stay at their pin level
   assign grant_s = !pins_s[`LBA_PIN_GRANT];
   assign lreq_s = !pins_s[`LBA_PIN_LREQ];
   assign own_s = pins_s[`LBA_PIN_OWN];
   assign ds_s = !pins_s[`LBA_PIN_DS];
   assign ack_s = pins_s[`LBA_PIN_ACK_HI:`LBA_PIN_ACK_LO];

   function automatic logic ack_seen(input lba_ack_t a);
      ack_seen = (a != `LBA_ACK_NONE);
   endfunction : ack_seen

   ////////////////////////////////////////////////////////////////////////
   // mode strap, taken once the synchronised pin shows the real level
   logic [1:0] strap_wait_r;
   logic [1:0] strap_wait_nxt;
   logic strap_done_r;
   logic strap_done_nxt;
   logic mode_r;
   logic mode_nxt;

   // strap sample once
   // the synchroniser restarts at its idle level, so sampling early would always pick arbiter
   always_comb begin
      strap_wait_nxt = strap_wait_r;
      strap_done_nxt = strap_done_r;
      mode_nxt = mode_r;
      if (!strap_done_r) begin
         if (strap_wait_r == `LBA_STRAP_WAIT) begin
            strap_done_nxt = 1'b1;
            mode_nxt = own_s;
         end else begin
            strap_wait_nxt = strap_wait_r + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         strap_wait_r <= 2'h0;
         strap_done_r <= 1'b0;
         mode_r <= 1'b0;
      end else begin
         strap_wait_r <= strap_wait_nxt;
         strap_done_r <= strap_done_nxt;
         mode_r <= mode_nxt;
      end
   end

   assign arbiter_mode = mode_r;

   ////////////////////////////////////////////////////////////////////////
   // arbitration and master cycle
   lba_arb_t arb_r;
   lba_arb_t arb_nxt;
   logic own_sel_r;
   logic own_sel_nxt;
   logic bus_free;
   logic take_grant;
   logic grant_ack_nxt;
   logic done_nxt;
   lba_ack_t ack_size_r;
   lba_ack_t ack_size_nxt;
   logic grant_ack_r;
   logic done_r;

   // ownership input only trusted in arbiter mode
   assign bus_free = !mode_r || own_s;
   assign take_grant = strap_done_r && grant_s && bus_free;

   // own request has priority; the local requester waits for the next round
   always_comb begin
      arb_nxt = arb_r;
      own_sel_nxt = own_sel_r;
      grant_ack_nxt = 1'b0;
      done_nxt = 1'b0;
      ack_size_nxt = ack_size_r;
      unique case (arb_r)
         ARB_IDLE: begin
            if (strap_done_r && (own_req || (lreq_s && mode_r))) begin
               arb_nxt = ARB_REQ;
               own_sel_nxt = own_req;
            end
         end
         ARB_REQ: begin
            // grant taken for self or passed on
            if (take_grant) begin
               if (own_sel_r) begin
                  arb_nxt = ARB_OWN;
                  grant_ack_nxt = 1'b1;
               end else begin
                  arb_nxt = ARB_LGNT;
               end
            end else if (!own_sel_r && !lreq_s) begin
               // requester gave up before the grant: no request left, so do not wait forever
               arb_nxt = ARB_IDLE;
            end
         end
         ARB_OWN: begin
            if (ack_seen(ack_s)) begin
               arb_nxt = ARB_IDLE;
               done_nxt = 1'b1;
               ack_size_nxt = ack_s;
            end
         end
         ARB_LGNT: begin
            if (!lreq_s) begin
               arb_nxt = ARB_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         arb_r <= ARB_IDLE;
         own_sel_r <= 1'b0;
         grant_ack_r <= 1'b0;
         done_r <= 1'b0;
         ack_size_r <= `LBA_ACK_NONE;
      end else begin
         arb_r <= arb_nxt;
         own_sel_r <= own_sel_nxt;
         grant_ack_r <= grant_ack_nxt;
         done_r <= done_nxt;
         ack_size_r <= ack_size_nxt;
      end
   end

   // request follows the local requester, plus own pending request
   assign cpu_request_out_n = !(lreq_s || (arb_r == ARB_REQ && own_sel_r));
   // grant to local requester only from the arbiter
   assign local_requester_grant_n = !(arb_r == ARB_LGNT && mode_r);
   // hold ownership while the bus is ours
   assign bus_own_oe = (arb_r == ARB_OWN);
   assign bus_own_out_n = !bus_own_oe;
   // strobe driven low throughout our cycle
   assign local_data_strobe_oe = (arb_r == ARB_OWN);
   assign local_data_strobe_out_n = !local_data_strobe_oe;
   assign grant_ack = grant_ack_r;
   assign cycle_done = done_r;
   assign ack_size = ack_size_r;

   ////////////////////////////////////////////////////////////////////////
   // register-access slave; every access with reg_sel high is acknowledged three clocks after the strobe pin falls
   lba_slv_t slv_r;
   lba_slv_t slv_nxt;
   logic strobe_nxt;
   logic strobe_r;

   // strobe only watched for own registers
   always_comb begin
      slv_nxt = slv_r;
      strobe_nxt = 1'b0;
      unique case (slv_r)
         SLV_IDLE: begin
            if (reg_sel && ds_s) begin
               slv_nxt = SLV_ACK;
               strobe_nxt = 1'b1;
            end
         end
         SLV_ACK: begin
            if (!ds_s) begin
               slv_nxt = SLV_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         slv_r <= SLV_IDLE;
         strobe_r <= 1'b0;
      end else begin
         slv_r <= slv_nxt;
         strobe_r <= strobe_nxt;
      end
   end

   assign transfer_size_ack_oe = (slv_r == SLV_ACK);
   assign transfer_size_ack_out_n = transfer_size_ack_oe ? `LBA_ACK_32 : `LBA_ACK_NONE;
   assign reg_strobe = strobe_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   grant_local_a: assert property (arb_r == ARB_REQ && !own_sel_r && take_grant |=> !local_requester_grant_n == mode_r) else $error("local grant not given");
   grant_own_a: assert property (arb_r == ARB_REQ && own_sel_r && take_grant |=> grant_ack ##1 !grant_ack) else $error("own grant not acknowledged");
   cpu_req_a: assert property (lreq_s |-> !cpu_request_out_n) else $error("bus request missing");
   slave_ignore_a: assert property (slv_r == SLV_IDLE && !reg_sel |=> !transfer_size_ack_oe && !reg_strobe) else $error("strobe not ignored");
   ack_hold_a: assert property ($rose(transfer_size_ack_oe) |-> transfer_size_ack_out_n == `LBA_ACK_32 && $past(ds_s)) else $error("ack without strobe");
   strap_mode_a: assert property ($rose(strap_done_r) |=> arbiter_mode == $past(own_s, 2) ##1 $stable(arbiter_mode)) else $error("mode strap wrong");
   own_drive_a: assert property (local_data_strobe_oe |-> bus_own_oe && !bus_own_out_n) else $error("ownership not held");
   bypass_grant_a: assert property (!arbiter_mode |-> local_requester_grant_n) else $error("grant in bypass");
   cycle_hold_a: assert property (arb_r == ARB_OWN && !ack_seen(ack_s) |=> !local_data_strobe_out_n && !cycle_done) else $error("cycle ended early");
   req_release_a: assert property (arb_r == ARB_LGNT && !lreq_s |=> arb_r == ARB_IDLE) else $error("request not released");
endmodule : lba_arbiter

// ---- lba_map.svh ----
`ifndef LBA_MAP_SVH
`define LBA_MAP_SVH

// synchroniser depth for every pin input
`define LBA_SYNC_STAGES 2
// number of synchronised pin inputs: grant, request, ownership, strobe, two acks
`define LBA_PIN_COUNT 6
// bit positions in the synchronised pin vector
`define LBA_PIN_GRANT 0
`define LBA_PIN_LREQ 1
`define LBA_PIN_OWN 2
`define LBA_PIN_DS 3
`define LBA_PIN_ACK_LO 4
`define LBA_PIN_ACK_HI 5
// acknowledge codes, active low, as seen on the two size lines
`define LBA_ACK_NONE 2'h3
`define LBA_ACK_32 2'h0
// clocks after reset release before the strap is taken: the synchroniser must fill first
`define LBA_STRAP_WAIT 2'h2
// reset value of the synchronised pins: all inactive high
`define LBA_PIN_IDLE 6'h3f

`endif

// ---- lba_pkg.sv ----
package lba_pkg;
   // size acknowledge pair, active low
   typedef logic [1:0] lba_ack_t;
   // bus ownership sequence, gray along idle-request-own
   typedef enum logic [1:0] {
      ARB_IDLE = 2'h0,
      ARB_REQ = 2'h1,
      ARB_OWN = 2'h3,
      ARB_LGNT = 2'h2
   } lba_arb_t;
   // register-access slave sequence
   typedef enum logic {
      SLV_IDLE = 1'h0,
      SLV_ACK = 1'h1
   } lba_slv_t;
endpackage : lba_pkg

// ---- lba_sync.sv ----
`timescale 1ns/1ps
`include "lba_map.svh"

module lba_sync #(
   parameter int WIDTH = `LBA_PIN_COUNT,
   parameter logic [WIDTH-1:0] IDLE = `LBA_PIN_IDLE
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pins,
   output logic [WIDTH-1:0] pins_s
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   // refuse a width the logic cannot serve
   if (WIDTH < 1) begin : g_bad_width
      $error("lba_sync width must be positive");
   end

   // first stage feeds only the second stage
   always_comb begin
      meta_nxt = pins;
      sync_nxt = meta_r;
   end

   // reset to the inactive level so nothing looks asserted at start
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_r <= IDLE;
         sync_r <= IDLE;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign pins_s = sync_r;
endmodule : lba_sync

// ---- lba_cpu_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// stand-in for the cpu and for the slave of the device's own cycles
module lba_cpu_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cpu_request_out_n,
   input wire logic strobe_n,
   input wire logic [3:0] lat,
   input wire lba_pkg::lba_ack_t ack_code,
   output logic cpu_grant_in_n,
   output lba_pkg::lba_ack_t ack_n
);
   import lba_pkg::*;
   int gcnt;
   int acnt;
   // grant after lat cycles; gone the edge after the request goes
   always_ff @(posedge clk_sys) begin
      if (!rst_n || cpu_request_out_n) begin
         gcnt <= 0;
         cpu_grant_in_n <= 1'b1;
      end else begin
         gcnt <= gcnt + 1;
         cpu_grant_in_n <= (gcnt < int'(lat));
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n || strobe_n) begin
         acnt <= 0;
         ack_n <= 2'h3; // pull-ups once released
      end else begin
         acnt <= acnt + 1;
         ack_n <= (acnt < int'(lat)) ? 2'h3 : ack_code;
      end
   end
endmodule : lba_cpu_model

// ---- lba_arbiter_bench.sv ----
`timescale 1ns/1ps
module lba_arbiter_bench;
   import lba_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic ext_own = 1'b1;
   logic bench_ds = 1'b1;
   logic lreq_n = 1'b1;
   logic own_req = 1'b0;
   logic reg_sel = 1'b0;
   logic [3:0] lat = 4'h1;
   lba_ack_t code = 2'h0;
   logic [15:0] rnd = 16'h5f0e;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   logic grant_n, req_n, lgnt_n, own_out_n, own_oe, ds_out_n, ds_oe, ack_oe;
   logic grant_ack, cycle_done, arbiter_mode, reg_strobe;
   lba_ack_t ack_out_n, p_ack_n, ack_size;
   // pin levels: driver wins, else the far side or the pull-up
   wire own_pin = own_oe ? own_out_n : ext_own;
   wire ds_pin = ds_oe ? ds_out_n : bench_ds;
   wire dev_ds_n = ~(ds_oe & ~ds_out_n);
   wire lba_ack_t ack_pin = ack_oe ? ack_out_n : p_ack_n;
   ////////////////////////////////////////////////////////////
   always #4 clk_sys = ~clk_sys;
   lba_arbiter dut_u (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cpu_grant_in_n(grant_n),
      .local_requester_request_n(lreq_n),
      .bus_own_in_n(own_pin),
      .local_data_strobe_in_n(ds_pin),
      .transfer_size_ack_in_n(ack_pin),
      .own_req(own_req),
      .reg_sel(reg_sel),
      .cpu_request_out_n(req_n),
      .local_requester_grant_n(lgnt_n),
      .bus_own_out_n(own_out_n),
      .bus_own_oe(own_oe),
      .local_data_strobe_out_n(ds_out_n),
      .local_data_strobe_oe(ds_oe),
      .transfer_size_ack_out_n(ack_out_n),
      .transfer_size_ack_oe(ack_oe),
      .grant_ack(grant_ack),
      .cycle_done(cycle_done),
      .ack_size(ack_size),
      .arbiter_mode(arbiter_mode),
      .reg_strobe(reg_strobe)
   );
   lba_cpu_model cpu_u (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cpu_request_out_n(req_n),
      .strobe_n(dev_ds_n),
      .lat(lat),
      .ack_code(code),
      .cpu_grant_in_n(grant_n),
      .ack_n(p_ack_n)
   );
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   // the size latched at cycle end is the code the slave gave
   function automatic lba_ack_t exp_size(input lba_ack_t c);
      return c;
   endfunction : exp_size
   function automatic logic sig(input int s);
      case (s)
         0: return grant_ack;
         1: return req_n;
         2: return lgnt_n;
         default: return ack_oe;
      endcase
   endfunction : sig
   task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // bounded wait, so a stuck output shows as a mismatch, not a hang
   task automatic waitv(input string nm, input int s, input logic v);
      for (int i = 0; i < 40 && sig(s) !== v; i++) @(negedge clk_sys);
      chk(nm, {2'h0, v}, {2'h0, sig(s)});
   endtask : waitv
   task automatic never(input string nm, input int s, input logic v);
      logic hit;
      hit = 1'b0;
      repeat (12) begin
         @(negedge clk_sys);
         hit |= (sig(s) === v);
      end
      chk(nm, 3'h0, {2'h0, hit});
   endtask : never
   task automatic do_reset(input logic strap);
      rst_n = 1'b0;
      ext_own = strap;
      repeat (16) @(negedge clk_sys);
      chk("reset drive", 3'h0, {own_oe, ds_oe, ack_oe});
      chk("reset size", 3'h3, {1'b0, ack_size});
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk("mode", {2'h0, strap}, {2'h0, arbiter_mode});
      $display("test reset done");
   endtask : do_reset
   // one own master cycle; busy keeps another owner on the line first
   task automatic own_cycle(input logic busy);
      own_req = 1'b1;
      if (busy) begin
         ext_own = 1'b0;
         never("held off", 0, 1'b1);
         ext_own = 1'b1;
      end
      waitv("grant ack", 0, 1'b1);
      chk("own drive", 3'h7, {own_oe, ~own_out_n, ds_oe});
      for (int i = 0; i < 60 && cycle_done !== 1'b1; i++) begin
         chk("strobe held", 3'h2, {1'b0, ds_oe, ds_out_n});
         @(negedge clk_sys);
      end
      chk("done", 3'h1, {2'h0, cycle_done});
      chk("size", {1'b0, exp_size(code)}, {1'b0, ack_size});
      own_req = 1'b0;
      @(negedge clk_sys);
      $display("test own cycle done");
   endtask : own_cycle
   task automatic local_grant();
      lreq_n = 1'b0;
      waitv("cpu req", 1, 1'b0);
      waitv("local grant", 2, 1'b0);
      repeat (5) @(negedge clk_sys);
      chk("grant holds", 3'h0, {1'b0, req_n, lgnt_n});
      lreq_n = 1'b1;
      waitv("req release", 1, 1'b1);
      waitv("grant release", 2, 1'b1);
      $display("test local grant done");
   endtask : local_grant
   task automatic slave(input logic sel);
      reg_sel = sel;
      bench_ds = 1'b0;
      if (sel) begin
         waitv("reg ack", 3, 1'b1);
         chk("reg strobe", 3'h1, {2'h0, reg_strobe});
         chk("ack code", 3'h0, {1'b0, ack_pin});
      end else begin
         never("stray ack", 3, 1'b1);
      end
      bench_ds = 1'b1;
      waitv("ack release", 3, 1'b0);
      reg_sel = 1'b0;
      @(negedge clk_sys);
      $display("test slave done");
   endtask : slave
   task automatic results();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         results();
      end
   end
   // main sequence: arbiter mode, then bypass with a floating line
   initial begin
      @(negedge clk_sys);
      do_reset(1'b1);
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr_next(rnd);
         lat = (k == 0) ? 4'h0 : rnd[3:0];
         code = lba_ack_t'(k % 3);
         own_cycle(k == 1);
      end
      local_grant();
      slave(1'b1);
      slave(1'b0);
      do_reset(1'b0);
      ext_own = 1'bx;
      own_cycle(1'b0);
      lreq_n = 1'b0;
      never("bypass grant", 2, 1'b0);
      lreq_n = 1'b1;
      results();
   end
endmodule : lba_arbiter_bench
